//--- hdl/crc_pkg.sv
// Shared constants, opcodes, timing and register map of the call and return control unit.
`default_nettype none
package crc_pkg;
    typedef enum logic [2:0] {
        ST_FETCH,
        ST_ED_FETCH,
        ST_RD_LO,
        ST_RD_HI,
        ST_PUSH_HI,
        ST_PUSH_LO,
        ST_POP_LO,
        ST_POP_HI
    } crc_state_e;

    // Machine cycle lengths and the opcode sample state, in clock states; one clock state is one clk_i cycle.
    localparam logic [2:0] T_FETCH = 3'h4;
    localparam logic [2:0] T_FETCH_RETCC = 3'h5;
    localparam logic [2:0] T_ED_FETCH = 3'h4;
    localparam logic [2:0] T_MEM = 3'h3;
    localparam logic [2:0] T_RD_HI_TAKEN = 3'h4;
    localparam logic [2:0] T_FETCH_SAMPLE = 3'h2;

    localparam logic [7:0] OP_SUB_EXIT = 8'hC9;
    localparam logic [7:0] OP_PREFIX_ED = 8'hED;
    localparam logic [7:0] OP_SERVICE_EXIT = 8'h4D;
    localparam logic [7:0] OP_INT_ENABLE = 8'hFB;
    localparam logic [7:0] OP_MASK_GROUP = 8'hC7;
    localparam logic [7:0] OP_RETCC_BASE = 8'hC0;
    localparam logic [7:0] OP_CALLCC_BASE = 8'hC4;

    localparam int FLAG_SIGN = 7;
    localparam int FLAG_ZERO = 6;
    localparam int FLAG_PARITY = 2;
    localparam int FLAG_CARRY = 0;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PC = 8'h04;
    localparam logic [7:0] REG_SP = 8'h08;
    localparam logic [7:0] REG_FLAGS = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_IE = 1;

    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'hFFFF;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
endpackage : crc_pkg
`default_nettype wire

//--- hdl/crc_cond_eval.sv
// Condition field evaluation against the flag byte.
`default_nettype none
module crc_cond_eval
    import crc_pkg::*;
(
    input wire logic [2:0] cc_i,
    input wire logic [7:0] flags_i,
    output logic true_o
);
    logic [3:0] flag_sel;

    // Pairs of codes test one flag; the low code bit asks for it set.
    assign flag_sel = {flags_i[FLAG_SIGN], flags_i[FLAG_PARITY],
                       flags_i[FLAG_CARRY], flags_i[FLAG_ZERO]};
    assign true_o = (flag_sel[cc_i[2:1]] == cc_i[0]);
endmodule : crc_cond_eval
`default_nettype wire

//--- hdl/crc_tstate_timer.sv
// Clock-state counter inside one machine cycle.
`default_nettype none
module crc_tstate_timer
    import crc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hold_i,
    input wire logic [2:0] len_i,
    output logic [2:0] tcnt_o,
    output logic last_o
);
    logic [2:0] tcnt_q;
    logic [2:0] tcnt_d;

    assign last_o = !hold_i && (tcnt_q == len_i - 3'h1);
    assign tcnt_d = hold_i ? 3'h0 : (last_o ? 3'h0 : tcnt_q + 3'h1);
    assign tcnt_o = tcnt_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tcnt_q <= 3'h0;
        end else begin
            tcnt_q <= tcnt_d;
        end
    end
endmodule : crc_tstate_timer
`default_nettype wire

//--- hdl/crc_core.sv
// Call and return sequencer with its memory port and Wishbone register slave.
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`default_nettype none
module crc_core
    import crc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [15:0] mem_addr_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic mem_m1_o,
    output logic [7:0] mem_wdata_o,
    input wire logic [7:0] mem_rdata_i,
    output logic service_exit_o
);
    crc_state_e state_q;
    crc_state_e state_d;
    logic [15:0] pc_q;
    logic [15:0] pc_d;
    logic [15:0] sp_q;
    logic [15:0] sp_d;
    logic [7:0] flags_q;
    logic [7:0] op_q;
    logic [7:0] op_d;
    logic [7:0] tgt_lo_q;
    logic [7:0] tgt_hi_q;
    logic run_q;
    logic ie_q;
    logic cond_q;
    logic [7:0] exit_cnt_q;
    logic [15:0] addr_q;
    logic rd_q;
    logic wr_q;
    logic m1_q;
    logic [7:0] wdata_q;
    logic exit_q;
    logic ack_q;
    logic [31:0] rdat_q;

    logic [2:0] tcnt;
    logic last;
    logic hold;
    logic [2:0] len;
    logic [2:0] cc_now;
    logic cond_now;
    logic is_retcc;
    logic is_callcc;
    logic opcode_sample;
    logic exit_seen;
    logic ie_set;
    logic bus_req;
    logic bus_wr;
    logic wr_ctrl;
    logic wr_pc;
    logic wr_sp;
    logic wr_flags;
    logic [15:0] addr_d;
    logic rd_d;
    logic wr_d;
    logic [7:0] wdata_d;
    logic [31:0] rdat_d;
    logic busy;

    // The core only halts on an instruction boundary, never in the middle of a push or pop.
    assign hold = !run_q && (state_q == ST_FETCH) && (tcnt == 3'h0);
    assign cc_now = op_q[5:3];
    assign is_retcc = ((op_q & OP_MASK_GROUP) == OP_RETCC_BASE);
    assign is_callcc = ((op_q & OP_MASK_GROUP) == OP_CALLCC_BASE);
    assign opcode_sample = !hold && (tcnt == T_FETCH_SAMPLE) &&
                           (state_q == ST_FETCH || state_q == ST_ED_FETCH);
    assign op_d = opcode_sample ? mem_rdata_i : op_q;
    assign exit_seen = opcode_sample && (state_q == ST_ED_FETCH) &&
                       (mem_rdata_i == OP_SERVICE_EXIT);
    assign ie_set = last && (state_q == ST_FETCH) && (op_q == OP_INT_ENABLE);

    crc_cond_eval u_cond (
        .cc_i(cc_now),
        .flags_i(flags_q),
        .true_o(cond_now)
    );

    always_comb begin
        case (state_q)
            ST_FETCH: len = (tcnt > T_FETCH_SAMPLE && is_retcc) ? T_FETCH_RETCC : T_FETCH;
            ST_ED_FETCH: len = T_ED_FETCH;
            ST_RD_HI: len = cond_now ? T_RD_HI_TAKEN : T_MEM;
            default: len = T_MEM;
        endcase
    end

    crc_tstate_timer u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .hold_i(hold),
        .len_i(len),
        .tcnt_o(tcnt),
        .last_o(last)
    );

    // Sequencing and register updates at the end of each machine cycle.
    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        sp_d = sp_q;
        if (last) begin
            case (state_q)
                ST_FETCH: begin
                    pc_d = pc_q + 16'h0001;
                    if (op_q == OP_PREFIX_ED) begin
                        state_d = ST_ED_FETCH;
                    end else if (op_q == OP_SUB_EXIT) begin
                        state_d = ST_POP_LO;
                    end else if (is_retcc) begin
                        state_d = cond_now ? ST_POP_LO : ST_FETCH;
                    end else if (is_callcc) begin
                        state_d = ST_RD_LO;
                    end
                end
                ST_ED_FETCH: begin
                    pc_d = pc_q + 16'h0001;
                    state_d = (op_q == OP_SERVICE_EXIT) ? ST_POP_LO : ST_FETCH;
                end
                ST_RD_LO: begin
                    pc_d = pc_q + 16'h0001;
                    state_d = ST_RD_HI;
                end
                ST_RD_HI: begin
                    // Both operands are consumed either way, so pc ends past the call.
                    pc_d = pc_q + 16'h0001;
                    state_d = cond_now ? ST_PUSH_HI : ST_FETCH;
                end
                ST_PUSH_HI: begin
                    sp_d = sp_q - 16'h0001;
                    state_d = ST_PUSH_LO;
                end
                ST_PUSH_LO: begin
                    sp_d = sp_q - 16'h0001;
                    pc_d = {tgt_hi_q, tgt_lo_q};
                    state_d = ST_FETCH;
                end
                ST_POP_LO: begin
                    pc_d = {pc_q[15:8], mem_rdata_i};
                    sp_d = sp_q + 16'h0001;
                    state_d = ST_POP_HI;
                end
                ST_POP_HI: begin
                    pc_d = {mem_rdata_i, pc_q[7:0]};
                    sp_d = sp_q + 16'h0001;
                    state_d = ST_FETCH;
                end
                default: state_d = ST_FETCH;
            endcase
        end
        if (wr_pc && !run_q) begin
            pc_d = wb_dat_i[15:0];
        end
        if (wr_sp && !run_q) begin
            sp_d = wb_dat_i[15:0];
        end
    end

    // Memory strobes are registered, so they lag the cycle start by one clock.
    always_comb begin
        case (state_q)
            ST_PUSH_HI: addr_d = sp_q - 16'h0001;
            ST_PUSH_LO: addr_d = sp_q - 16'h0001;
            ST_POP_LO: addr_d = sp_q;
            ST_POP_HI: addr_d = sp_q;
            default: addr_d = pc_q;
        endcase
    end
    assign wdata_d = (state_q == ST_PUSH_HI) ? pc_q[15:8] : pc_q[7:0];
    assign wr_d = !last && (state_q == ST_PUSH_HI || state_q == ST_PUSH_LO);
    assign rd_d = !hold && !last && !(state_q == ST_PUSH_HI || state_q == ST_PUSH_LO);

    // Wishbone slave: one wait state, write applied at the edge that raises ack.
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign bus_wr = bus_req && wb_we_i;
    assign wr_ctrl = bus_wr && (wb_adr_i == REG_CTRL) && wb_sel_i[0];
    assign wr_pc = bus_wr && (wb_adr_i == REG_PC) && (wb_sel_i[1:0] == 2'h3);
    assign wr_sp = bus_wr && (wb_adr_i == REG_SP) && (wb_sel_i[1:0] == 2'h3);
    assign wr_flags = bus_wr && (wb_adr_i == REG_FLAGS) && wb_sel_i[0];
    assign busy = !(state_q == ST_FETCH && tcnt == 3'h0);

    always_comb begin
        case (wb_adr_i)
            REG_CTRL: rdat_d = {30'h00000000, ie_q, run_q};
            REG_PC: rdat_d = {16'h0000, pc_q};
            REG_SP: rdat_d = {16'h0000, sp_q};
            REG_FLAGS: rdat_d = {24'h000000, flags_q};
            REG_STATUS: rdat_d = {16'h0000, exit_cnt_q, 6'h00, cond_q, busy};
            default: rdat_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_FETCH;
            pc_q <= PC_RESET;
            sp_q <= SP_RESET;
            op_q <= 8'h00;
        end else begin
            state_q <= state_d;
            pc_q <= pc_d;
            sp_q <= sp_d;
            op_q <= op_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tgt_lo_q <= 8'h00;
            tgt_hi_q <= 8'h00;
            cond_q <= 1'b0;
        end else if (last && state_q == ST_RD_LO) begin
            tgt_lo_q <= mem_rdata_i;
        end else if (last && state_q == ST_RD_HI) begin
            tgt_hi_q <= mem_rdata_i;
            cond_q <= cond_now;
        end
    end

    // Flags are written only by software; no sequence here touches them.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q <= FLAGS_RESET;
        end else if (wr_flags) begin
            flags_q <= wb_dat_i[7:0];
        end
    end

    // The enable opcode sets the bit and wins over a software clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_q <= 1'b0;
            ie_q <= 1'b0;
        end else begin
            run_q <= wr_ctrl ? wb_dat_i[CTRL_RUN] : run_q;
            ie_q <= ie_set | (wr_ctrl ? wb_dat_i[CTRL_IE] : ie_q);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            exit_q <= 1'b0;
            exit_cnt_q <= 8'h00;
        end else begin
            exit_q <= exit_seen;
            exit_cnt_q <= exit_cnt_q + {7'h00, exit_seen};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_q <= 16'h0000;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            m1_q <= 1'b0;
            wdata_q <= 8'h00;
        end else begin
            addr_q <= addr_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            m1_q <= rd_d && (state_q == ST_FETCH || state_q == ST_ED_FETCH);
            wdata_q <= wdata_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q <= bus_req;
            rdat_q <= bus_req ? rdat_d : rdat_q;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign mem_addr_o = addr_q;
    assign mem_rd_o = rd_q;
    assign mem_wr_o = wr_q;
    assign mem_m1_o = m1_q;
    assign mem_wdata_o = wdata_q;
    assign service_exit_o = exit_q;

    // Clocks since the current instruction began, read only by the checks below.
    logic [4:0] ins_clk_q;
    logic sw_write;
    always_ff @(posedge clk_i) begin
        if (rst_i || hold || (last && state_d == ST_FETCH)) begin
            ins_clk_q <= 5'h00;
        end else begin
            ins_clk_q <= ins_clk_q + 5'h01;
        end
    end
    assign sw_write = bus_wr;

    AST_CALL_TARGET: assert property (@(posedge clk_i) disable iff (rst_i)
        (last && state_q == ST_PUSH_LO) |=> (pc_q == {tgt_hi_q, tgt_lo_q}) && state_q == ST_FETCH)
        else $error("call did not load the target address");

    AST_CALL_NOSTACK: assert property (@(posedge clk_i) disable iff (rst_i)
        (last && state_q == ST_RD_HI && !cond_now && !sw_write) |=>
        (state_q == ST_FETCH) && $stable(sp_q))
        else $error("untaken call touched the stack");

    AST_PUSH_ORDER: assert property (@(posedge clk_i) disable iff (rst_i)
        (mem_wr_o && state_q == ST_PUSH_HI) |-> (mem_addr_o == sp_q - 16'h0001) &&
        (mem_wdata_o == pc_q[15:8]))
        else $error("high byte push at wrong address or data");

    AST_CALL_TAKEN_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
        (last && state_q == ST_PUSH_LO) |-> (ins_clk_q == 5'h10))
        else $error("taken call is not 17 clocks");

    AST_CALL_SKIP_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
        (last && state_q == ST_RD_HI && !cond_now) |-> (ins_clk_q == 5'h09))
        else $error("untaken call is not 10 clocks");

    AST_POP_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
        (last && state_q == ST_POP_HI && !sw_write) |=>
        (pc_q[15:8] == $past(mem_rdata_i)) && (sp_q == $past(sp_q) + 16'h0001))
        else $error("pop of the high byte went wrong");

    AST_RETCC_SKIP: assert property (@(posedge clk_i) disable iff (rst_i)
        (last && state_q == ST_FETCH && is_retcc && !cond_now && !sw_write) |->
        (ins_clk_q == 5'h04) ##1 (state_q == ST_FETCH && $stable(sp_q)))
        else $error("untaken return moved the stack");

    AST_EXIT_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
        (last && state_q == ST_POP_HI && op_q == OP_SERVICE_EXIT) |-> (ins_clk_q == 5'h0D))
        else $error("interrupt return is not 14 clocks");

    AST_EXIT_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        service_exit_o |-> !$past(service_exit_o) ##[1:5] (state_q == ST_POP_LO))
        else $error("exit pulse without a following pop");

    AST_IE_KEPT: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == ST_POP_LO && !wr_ctrl) |=> $stable(ie_q))
        else $error("return altered the interrupt enable");

    AST_FLAGS_KEPT: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_flags |=> $stable(flags_q))
        else $error("flags changed without a software write");

    COV_CALL_TAKEN: cover property (@(posedge clk_i) disable iff (rst_i)
        last && state_q == ST_PUSH_LO);
    COV_CALL_SKIP: cover property (@(posedge clk_i) disable iff (rst_i)
        last && state_q == ST_RD_HI && !cond_now);
    COV_SERVICE_EXIT: cover property (@(posedge clk_i) disable iff (rst_i)
        service_exit_o);
    COV_RETCC_SKIP: cover property (@(posedge clk_i) disable iff (rst_i)
        last && state_q == ST_FETCH && is_retcc && !cond_now);
endmodule : crc_core
`default_nettype wire

//--- verif/crc_mem_model.sv
// Behavioural program and stack memory with an end-of-service watcher.
`default_nettype none
module crc_mem_model
    import crc_pkg::*;
(
    input wire logic clk_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic mem_rd_i,
    input wire logic mem_wr_i,
    input wire logic mem_m1_i,
    input wire logic [7:0] mem_wdata_i,
    output logic [7:0] mem_rdata_o,
    output var int exit_seen_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q;
    logic [7:0] prev_op_q;
    logic m1_q;
    logic svc_hi_q;
    logic svc_lo_q;

    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'h00;
        end
        last_q = 8'h00;
        prev_op_q = 8'h00;
        m1_q = 1'b0;
        svc_hi_q = 1'b0;
        svc_lo_q = 1'b0;
        exit_seen_o = 0;
    end

    // An idle data bus shows the inverse of the last byte, so a late sample cannot pass by luck.
    assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : ~last_q;

    always @(posedge clk_i) begin
        if (mem_wr_i) begin
            mem[mem_addr_i] <= mem_wdata_i;
        end
        if (mem_rd_i) begin
            last_q <= mem[mem_addr_i];
        end
        if (mem_m1_i && !m1_q) begin
            if (prev_op_q == OP_PREFIX_ED && mem[mem_addr_i] == OP_SERVICE_EXIT) begin
                exit_seen_o <= exit_seen_o + 1;
                // The innermost routine ends first, so the nested higher device releases first.
                if (svc_hi_q) begin
                    svc_hi_q <= 1'b0;
                end else begin
                    svc_lo_q <= 1'b0;
                end
            end
            prev_op_q <= mem[mem_addr_i];
        end
        m1_q <= mem_m1_i;
    end
endmodule : crc_mem_model
`default_nettype wire

//--- verif/tb.sv
// Self-checking testbench for the call and return sequencer.
`default_nettype none
module tb
    import crc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mem_rd_o, mem_wr_o, mem_m1_o;
    logic service_exit_o, m1_q;
    logic [7:0] wb_adr_i, mem_wdata_o, mem_rdata_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [15:0] mem_addr_o;
    logic [15:0] fa[$];
    int ft[$];
    int cyc_n = 0, exit_n = 0, exit_seen, err_count = 0, compares = 0;

    crc_core i_crc_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
        .mem_wr_o(mem_wr_o), .mem_m1_o(mem_m1_o), .mem_wdata_o(mem_wdata_o),
        .mem_rdata_i(mem_rdata_i), .service_exit_o(service_exit_o));
    crc_mem_model i_crc_mem_model (.clk_i(clk_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
        .mem_wr_i(mem_wr_o), .mem_m1_i(mem_m1_o), .mem_wdata_i(mem_wdata_o),
        .mem_rdata_o(mem_rdata_i), .exit_seen_o(exit_seen));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // Opcode fetch starts are logged so instruction lengths come from fetch-to-fetch spacing.
    always @(posedge clk_i) begin
        cyc_n++;
        if (mem_m1_o === 1'b1 && m1_q !== 1'b1) begin
            fa.push_back(mem_addr_o);
            ft.push_back(cyc_n);
        end
        if (service_exit_o === 1'b1) begin
            exit_n++;
        end
        m1_q = mem_m1_o;
    end

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] rdat);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            chk("wb_ack_o", 1, wb_ack_o);
            complete_run();
        end
    endtask : wb

    task automatic wb_wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] r;
        wb(1'b1, adr, dat, r);
    endtask : wb_wr

    task automatic wb_rd(input logic [7:0] adr, output logic [31:0] r);
        wb(1'b0, adr, 32'h00000000, r);
    endtask : wb_rd

    task automatic poke(input logic [15:0] a, input logic [7:0] v);
        i_crc_mem_model.mem[a] = v;
    endtask : poke

    // Flag byte that makes condition field cc true (t = 1) or false (t = 0).
    function automatic logic [7:0] cond_fl(input int cc, input int t);
        int pos;
        pos = (cc / 2 == 0) ? FLAG_ZERO : (cc / 2 == 1) ? FLAG_CARRY :
              (cc / 2 == 2) ? FLAG_PARITY : FLAG_SIGN;
        return 8'((t == 1 ? cc % 2 : 1 - cc % 2) << pos);
    endfunction : cond_fl

    task automatic run_case(input logic [15:0] pc, input logic [15:0] sp, input logic [7:0] fl,
        input logic ie, input int nidx, input logic [15:0] nxt, input int len,
        input logic [15:0] esp);
        logic [31:0] r;
        int n;
        wb_wr(REG_PC, {16'h0000, pc});
        wb_wr(REG_SP, {16'h0000, sp});
        wb_wr(REG_FLAGS, {24'h000000, fl});
        fa.delete();
        ft.delete();
        wb_wr(REG_CTRL, {30'h00000000, ie, 1'b1});
        n = 0;
        while (fa.size() <= nidx && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        wb_wr(REG_CTRL, {30'h00000000, ie, 1'b0});
        n = 0;
        do begin
            wb_rd(REG_STATUS, r);
            n++;
        end while (r[0] !== 1'b0 && n < 20);
        if (r[0] !== 1'b0) begin
            chk("halt", 32'h00000000, {31'h00000000, r[0]});
            complete_run();
        end
        if (fa.size() <= nidx) begin
            chk("fetch count", nidx + 1, fa.size());
            complete_run();
        end
        chk("first fetch", {16'h0000, pc}, {16'h0000, fa[0]});
        chk("next fetch", {16'h0000, nxt}, {16'h0000, fa[nidx]});
        chk("clock states", len, ft[nidx] - ft[0]);
        wb_rd(REG_SP, r);
        chk("sp", {16'h0000, esp}, r);
        wb_rd(REG_FLAGS, r);
        chk("flags", {24'h000000, fl}, r);
        wb_rd(REG_CTRL, r);
        chk("ie", {31'h00000000, ie}, {31'h00000000, r[1]});
    endtask : run_case

    task automatic t_regs();
        logic [31:0] r;
        wb_rd(REG_PC, r);
        chk("pc reset", {16'h0000, PC_RESET}, r);
        wb_rd(REG_SP, r);
        chk("sp reset", {16'h0000, SP_RESET}, r);
        wb_rd(8'h20, r);
        chk("unmapped", 32'h00000000, r);
        $display("t_regs done");
    endtask : t_regs

    task automatic t_call_cc();
        logic [15:0] pc, tgt, rtn;
        logic [31:0] r;
        for (int cc = 0; cc < 8; cc++) begin
            for (int t = 0; t < 2; t++) begin
                pc = 16'h1000 + 16'(cc * 32 + t * 16);
                tgt = {8'h40 + 8'(cc), 8'h10 + 8'(t)};
                rtn = pc + 16'h0003;
                poke(pc, OP_CALLCC_BASE | 8'(cc << 3));
                poke(pc + 16'h0001, tgt[7:0]);
                poke(pc + 16'h0002, tgt[15:8]);
                poke(16'h3001, 8'h5A);
                poke(16'h3000, 8'h5A);
                run_case(pc, 16'h3002, cond_fl(cc, t), 1'b0, 1, t ? tgt : rtn, t ? 17 : 10,
                         t ? 16'h3000 : 16'h3002);
                chk("push high", {24'h0, t ? rtn[15:8] : 8'h5A},
                    {24'h0, i_crc_mem_model.mem[16'h3001]});
                chk("push low", {24'h0, t ? rtn[7:0] : 8'h5A},
                    {24'h0, i_crc_mem_model.mem[16'h3000]});
                wb_rd(REG_STATUS, r);
                chk("call condition", t, {31'h00000000, r[1]});
            end
        end
        $display("t_call_cc done");
    endtask : t_call_cc

    task automatic t_sub_exit();
        poke(16'h3535, OP_SUB_EXIT);
        poke(16'h2000, 8'hB5);
        poke(16'h2001, 8'h18);
        run_case(16'h3535, 16'h2000, 8'hA5, 1'b0, 1, 16'h18B5, 10, 16'h2002);
        $display("t_sub_exit done");
    endtask : t_sub_exit

    task automatic t_sub_exit_cc();
        logic [15:0] pc, tgt;
        for (int cc = 0; cc < 8; cc++) begin
            for (int t = 0; t < 2; t++) begin
                pc = 16'h5000 + 16'(cc * 32 + t * 16);
                tgt = {8'h60 + 8'(cc), 8'h20 + 8'(t)};
                poke(pc, OP_RETCC_BASE | 8'(cc << 3));
                poke(16'h2100, tgt[7:0]);
                poke(16'h2101, tgt[15:8]);
                run_case(pc, 16'h2100, cond_fl(cc, t), 1'b0, 1, t ? tgt : pc + 16'h0001,
                         t ? 11 : 5, t ? 16'h2102 : 16'h2100);
            end
        end
        $display("t_sub_exit_cc done");
    endtask : t_sub_exit_cc

    task automatic t_service_exit();
        logic [31:0] r;
        logic hi_en, lo_en;
        // Two chained peripherals are in service, the higher one nested inside the lower one.
        i_crc_mem_model.svc_hi_q = 1'b1;
        i_crc_mem_model.svc_lo_q = 1'b1;
        for (int ie = 0; ie < 2; ie++) begin
            poke(16'h7000 + 16'(ie * 16), OP_PREFIX_ED);
            poke(16'h7001 + 16'(ie * 16), OP_SERVICE_EXIT);
            poke(16'h2200, 8'h80 + 8'(ie));
            poke(16'h2201, 8'h73);
            run_case(16'h7000 + 16'(ie * 16), 16'h2200, 8'hFF, ie[0], 2, 16'h7380 + 16'(ie),
                     14, 16'h2202);
            hi_en = !i_crc_mem_model.svc_hi_q;
            lo_en = !i_crc_mem_model.svc_lo_q;
            chk("chain enables", {30'h00000000, 1'b1, ie[0]},
                {30'h00000000, hi_en, lo_en});
        end
        chk("exit pulses", 2, exit_n);
        chk("exits seen by peripheral", 2, exit_seen);
        wb_rd(REG_STATUS, r);
        chk("exit count", 32'h00000002, {24'h0, r[15:8]});
        $display("t_service_exit done");
    endtask : t_service_exit

    initial begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h00000000;
        m1_q = 1'b0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_call_cc();
        t_sub_exit();
        t_sub_exit_cc();
        t_service_exit();
        complete_run();
    end
endmodule : tb
`default_nettype wire
